/* File: dv/ssp_host.sv */
// host model that issues commands and catches the answers
`timescale 1ns/1ns
`default_nettype none
module ssp_host (
    input wire logic clock_i,
    input wire ssp_pkg::ssp_resp_t resp_i,
    output ssp_pkg::ssp_cmd_t cmd_o
);
    ssp_pkg::ssp_resp_t last; // answer to the latest command
    initial begin
        cmd_o = '0;
    end
    // one command across one taking edge; released value is scrambled
    task automatic send(input ssp_pkg::ssp_op_t op, input logic [23:0] v);
        @(negedge clock_i);
        cmd_o = {1'b1, op, v};
        @(negedge clock_i);
        cmd_o = {1'b0, op, ~v};
        last = resp_i;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the supply settings and status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {
        ssp_pkg::ssp_op_t ws;
        logic [23:0] wv;
        ssp_pkg::ssp_op_t rd;
        logic [23:0] ev;
    } ssp_row_t;
    localparam logic [23:0] Z = 24'h00_0000;
    localparam logic [23:0] ONE = 24'h00_0001;
    logic clock_i;
    logic rst_i;
    ssp_pkg::ssp_cmd_t cmd;
    ssp_pkg::ssp_oper_bits_t oper;
    ssp_pkg::ssp_ques_bits_t ques;
    ssp_pkg::ssp_resp_t resp;
    logic err_post;
    logic nvm_store;
    logic [15:0] err_code;
    logic [7:0] sb;
    logic [23:0] setpoint;
    logic [23:0] nvm_pos;
    logic [23:0] nvm_neg;
    logic [23:0] pos_guard;
    logic [23:0] neg_guard;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    // write, then read back: operation, value, query, expected answer
    ssp_row_t rows[9] = '{
        '{ssp_pkg::OP_NEG_GUARD_SET, 24'h00_03e8, ssp_pkg::OP_NEG_GUARD_GET, 24'h00_03e8},
        '{ssp_pkg::OP_POS_GUARD_SET, 24'h00_8e08, ssp_pkg::OP_POS_GUARD_GET, 24'h00_8e08},
        '{ssp_pkg::OP_CEIL_POS_SET, 24'h00_4e20, ssp_pkg::OP_CEIL_POS_GET, 24'h00_4e20},
        '{ssp_pkg::OP_CEIL_NEG_SET, 24'h00_7530, ssp_pkg::OP_CEIL_NEG_GET, 24'h00_7530},
        '{ssp_pkg::OP_STAGE_SET, 24'h00_1388, ssp_pkg::OP_STAGE_GET, 24'h00_1388},
        '{ssp_pkg::OP_OPER_MASK_SET, 24'h00_ffff, ssp_pkg::OP_OPER_MASK_GET, 24'h00_5f60},
        '{ssp_pkg::OP_QUES_MASK_SET, 24'h00_ffff, ssp_pkg::OP_QUES_MASK_GET, 24'h00_704b},
        '{ssp_pkg::OP_PRESET, Z, ssp_pkg::OP_OPER_MASK_GET, Z},
        '{ssp_pkg::OP_PRESET, Z, ssp_pkg::OP_QUES_MASK_GET, 24'h00_004b}};
    ssp_top #(.RATED_MV(36000)) ssp_top_inst (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd),
        .oper_cond_i(oper), .ques_cond_i(ques), .resp_o(resp), .err_post_o(err_post), .err_code_o(err_code),
        .setpoint_o(setpoint), .pos_guard_o(pos_guard), .neg_guard_o(neg_guard), .nvm_store_o(nvm_store),
        .nvm_pos_ceil_o(nvm_pos), .nvm_neg_ceil_o(nvm_neg), .status_byte_o(sb));
    ssp_host ssp_host_inst (.clock_i(clock_i), .resp_i(resp), .cmd_o(cmd));
    // free running clock, 8 ns
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // query and compare the first answer value
    task automatic q(input ssp_pkg::ssp_op_t op, input logic [23:0] e);
        ssp_host_inst.send(op, Z);
        chk(op.name(), e, ssp_host_inst.last.first);
        chk("resp valid", ONE, 24'(ssp_host_inst.last.valid));
    endtask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (8) @(negedge clock_i);
        rst_i = 1'b0;
    endtask
    // let conditions cross the synchronisers
    task automatic settle();
        repeat (6) @(negedge clock_i);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        oper = '0;
        ques = '0;
        do_reset();
        foreach (rows[i]) begin
            ssp_host_inst.send(rows[i].ws, rows[i].wv);
            q(rows[i].rd, rows[i].ev);
        end
        // reset in mid-run, then ceiling pair order and persist
        do_reset();
        q(ssp_pkg::OP_OPER_MASK_GET, Z);
        ssp_host_inst.send(ssp_pkg::OP_CEIL_BOTH_SET, 24'h00_61a8);
        ssp_host_inst.send(ssp_pkg::OP_CEIL_POS_SET, 24'h00_5dc0);
        q(ssp_pkg::OP_CEIL_BOTH_GET, 24'h00_5dc0);
        chk("ceil second", 24'h00_61a8, ssp_host_inst.last.second);
        chk("pos guard", 24'h00_5dc0, pos_guard);
        chk("neg guard", 24'h00_61a8, neg_guard);
        ssp_host_inst.send(ssp_pkg::OP_PERSIST, Z);
        chk("store", ONE, 24'(nvm_store));
        chk("nvm pos", 24'h00_5dc0, nvm_pos);
        chk("nvm neg", 24'h00_61a8, nvm_neg);
        // out of range staged value refused
        chk("err code", Z, 24'(err_code));
        ssp_host_inst.send(ssp_pkg::OP_STAGE_SET, 24'h00_1388);
        ssp_host_inst.send(ssp_pkg::OP_STAGE_SET, 24'h00_8ca1);
        chk("err post", ONE, 24'(err_post));
        chk("err code", 24'h00_ff22, 24'(err_code));
        q(ssp_pkg::OP_STAGE_GET, 24'h00_1388);
        // clamp to software cap, then trigger
        ssp_host_inst.send(ssp_pkg::OP_CAP_SET, 24'h00_2710);
        ssp_host_inst.send(ssp_pkg::OP_STAGE_SET, 24'h00_4e20);
        chk("err post", Z, 24'(err_post));
        q(ssp_pkg::OP_STAGE_GET, 24'h00_2710);
        chk("setpoint", Z, setpoint);
        ssp_host_inst.send(ssp_pkg::OP_TRIGGER, Z);
        chk("setpoint", 24'h00_2710, setpoint);
        // operation group: live condition, latched events, summary
        ssp_host_inst.send(ssp_pkg::OP_PRESET, Z);
        ssp_host_inst.send(ssp_pkg::OP_OPER_MASK_SET, 24'h00_0400);
        oper = ssp_pkg::ssp_oper_bits_t'(16'hffff);
        ques = ssp_pkg::ssp_ques_bits_t'(16'hffff);
        settle();
        q(ssp_pkg::OP_OPER_COND_GET, 24'h00_5f60);
        q(ssp_pkg::OP_OPER_COND_GET, 24'h00_5f60);
        chk("oper sum", ONE, 24'(sb[7]));
        q(ssp_pkg::OP_OPER_EVENT_GET, 24'h00_5f60);
        q(ssp_pkg::OP_OPER_EVENT_GET, Z);
        settle();
        chk("oper sum", Z, 24'(sb[7]));
        // questionable group: only bits 13 and 12 hold after the fall
        q(ssp_pkg::OP_QUES_COND_GET, 24'h00_704b);
        chk("ques sum", ONE, 24'(sb[3]));
        // enable only the latched pair so the summary must come from held events
        ssp_host_inst.send(ssp_pkg::OP_QUES_MASK_SET, 24'h00_3000);
        ques = '0;
        settle();
        chk("ques sum", ONE, 24'(sb[3]));
        q(ssp_pkg::OP_QUES_EVENT_GET, 24'h00_3000);
        q(ssp_pkg::OP_QUES_EVENT_GET, Z);
        chk("ques sum", Z, 24'(sb[3]));
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: hw/ssp_event_merge.sv */
// event latch update and summary for one status group
`timescale 1ns/1ns
`default_nettype none
module ssp_event_merge #(
    parameter logic [15:0] USED = 16'hffff,
    parameter logic [15:0] LATCHED = 16'hffff
) (
    input wire logic [15:0] cond_i,
    input wire logic [15:0] prev_i,
    input wire logic [15:0] event_i,
    input wire logic [15:0] mask_i,
    input wire logic clear_i,
    output logic [15:0] next_event_o,
    output logic [15:0] view_o,
    output logic next_summary_o
);
    // rising edges of latching conditions
    logic [15:0] rise;

    always_comb begin
        rise = cond_i & ~prev_i & LATCHED & USED;
        // a new event wins over the clear of the same cycle
        next_event_o = (clear_i ? 16'h0000 : event_i) | rise;
        // what a read returns now: latched bits plus live unlatched bits
        view_o = ((event_i & LATCHED) | (prev_i & ~LATCHED)) & USED;
        // summary as it will stand next cycle
        next_summary_o = |((((next_event_o & LATCHED) | (cond_i & ~LATCHED)) & USED) & mask_i);
    end
endmodule
`default_nettype wire

/* File: hw/ssp_pkg.sv */
// shared constants and carrier types for the supply settings and status block
package ssp_pkg;
    // voltage word width, millivolt units
    localparam int VAL_W = 24;
    // status register width
    localparam int REG_W = 16;
    // headroom above rated voltage allowed for guards and ceilings, percent
    localparam int unsigned GUARD_MARGIN_PCT = 1;
    localparam int unsigned PCT_BASE = 100;
    // bits that exist in the operation group
    localparam logic [15:0] OPER_USED = 16'h5f60;
    // bits that exist in the questionable group
    localparam logic [15:0] QUES_USED = 16'h704b;
    // operation bits all latch on rising condition
    localparam logic [15:0] OPER_LATCHED = 16'h5f60;
    // questionable bits that latch, the rest pass live
    localparam logic [15:0] QUES_LATCHED = 16'h3000;
    // preset values, 8193 and 255, masked to used bits when loaded
    localparam logic [15:0] OPER_PRESET = 16'h2001;
    localparam logic [15:0] QUES_PRESET = 16'h00ff;
    // value of masks, events and conditions after reset
    localparam logic [15:0] REG_RESET = 16'h0000;
    // error code -222, data out of range
    localparam logic [15:0] ERR_OUT_OF_RANGE = 16'hff22;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    // staged value and setpoint after reset
    localparam logic [VAL_W-1:0] VOLT_RESET = 24'h00_0000;
    // summary bit positions in the status byte
    localparam int SB_OPER_BIT = 7;
    localparam int SB_QUES_BIT = 3;

    // command and query codes
    typedef enum logic [4:0] {
        OP_NONE, OP_NEG_GUARD_SET, OP_NEG_GUARD_GET, OP_POS_GUARD_SET, OP_POS_GUARD_GET,
        OP_CEIL_BOTH_SET, OP_CEIL_BOTH_GET, OP_CEIL_NEG_SET, OP_CEIL_NEG_GET,
        OP_CEIL_POS_SET, OP_CEIL_POS_GET, OP_STAGE_SET, OP_STAGE_GET, OP_TRIGGER,
        OP_CAP_SET, OP_CAP_GET, OP_PERSIST, OP_OPER_COND_GET, OP_OPER_MASK_SET,
        OP_OPER_MASK_GET, OP_OPER_EVENT_GET, OP_QUES_COND_GET, OP_QUES_MASK_SET,
        OP_QUES_MASK_GET, OP_QUES_EVENT_GET, OP_PRESET
    } ssp_op_t;

    // one decoded command or query
    typedef struct packed {
        logic valid;
        ssp_op_t op;
        logic [VAL_W-1:0] value;
    } ssp_cmd_t;

    // one query answer, first and second value
    typedef struct packed {
        logic valid;
        logic [VAL_W-1:0] first;
        logic [VAL_W-1:0] second;
    } ssp_resp_t;

    // operation condition bits, msb is bit 15
    typedef struct packed {
        logic nu15;
        logic sequence_running;
        logic nu13;
        logic sequence_done;
        logic sample_done;
        logic const_current_state;
        logic pulse_done;
        logic const_voltage_state;
        logic nu7;
        logic pulse_primed;
        logic awaiting_trigger;
        logic [4:0] nu4_0;
    } ssp_oper_bits_t;

    // questionable condition bits, msb is bit 15
    typedef struct packed {
        logic nu15;
        logic absorbing_energy;
        logic current_fault;
        logic voltage_fault;
        logic [4:0] nu11_7;
        logic follower_fault;
        logic [1:0] nu5_4;
        logic thermal_fault;
        logic nu2;
        logic current_regulation_fault;
        logic voltage_regulation_fault;
    } ssp_ques_bits_t;
endpackage

/* File: hw/ssp_sync.sv */
// two stage synchroniser for the analogue status inputs
`timescale 1ns/1ns
`default_nettype none
module ssp_sync #(
    parameter int W = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // both stages in one state word
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ssp_sync_state_t;

    ssp_sync_state_t st;
    ssp_sync_state_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.meta = async_i;
        next_st.stable = st.meta;
    end

    // register both stages
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;
endmodule
`default_nettype wire

/* File: hw/ssp_top.sv */
// supply protection limits, staged voltage and status groups
`timescale 1ns/1ns
`default_nettype none
// Function
// [RULE1] store and return negative protection guard
// [RULE2] store and return positive protection guard
// [RULE3] one command sets both ceilings; persist separately
// [RULE4] ceiling query answers positive then negative
// [RULE5] separate ceilings, own queries, persisted on update; code persists them only on OP_PERSIST
// [RULE6] staged value moves to setpoint on trigger
// [RULE7] staged value above model maximum posts -222
// [RULE8] staged value above software cap is clamped
// [RULE9] operation condition live, reading leaves unchanged
// [RULE10] operation bit positions fixed, unused bits empty
// [RULE11] status byte bit 7 summarises operation
// [RULE12] operation events latch, read clears them
// [RULE13] operation mask writable and read back
// [RULE14] preset loads masks 8193 and 255; code masks them to used bits, loading 0 and 75
// [RULE15] questionable: bits 13,12 latch, read clears
// [RULE16] questionable bit positions fixed, unused bits empty
// [RULE17] questionable condition live, one means active
// [RULE18] both regulation faults may show together
// [RULE19] status byte bit 3 summarises questionable
// [RULE20] unused bits read zero, writes ignored
module ssp_top #(
    parameter int unsigned RATED_MV = 36000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire ssp_pkg::ssp_cmd_t cmd_i,
    input wire ssp_pkg::ssp_oper_bits_t oper_cond_i,
    input wire ssp_pkg::ssp_ques_bits_t ques_cond_i,
    output ssp_pkg::ssp_resp_t resp_o,
    output logic err_post_o,
    output logic [15:0] err_code_o,
    output logic [ssp_pkg::VAL_W-1:0] setpoint_o,
    output logic [ssp_pkg::VAL_W-1:0] pos_guard_o,
    output logic [ssp_pkg::VAL_W-1:0] neg_guard_o,
    output logic nvm_store_o,
    output logic [ssp_pkg::VAL_W-1:0] nvm_pos_ceil_o,
    output logic [ssp_pkg::VAL_W-1:0] nvm_neg_ceil_o,
    output logic [7:0] status_byte_o
);
    localparam int VW = ssp_pkg::VAL_W;
    // model maximum and guard maximum, rated plus margin rounded down
    localparam logic [VW-1:0] MODEL_MAX = VW'(RATED_MV);
    localparam logic [VW-1:0] GUARD_MAX =
        VW'((RATED_MV * (ssp_pkg::PCT_BASE + ssp_pkg::GUARD_MARGIN_PCT)) / ssp_pkg::PCT_BASE);

    // whole block state
    typedef struct packed {
        logic [VW-1:0] pos_guard;
        logic [VW-1:0] neg_guard;
        logic [VW-1:0] pos_ceil;
        logic [VW-1:0] neg_ceil;
        logic [VW-1:0] cap;
        logic [VW-1:0] staged;
        logic [VW-1:0] setpoint;
        logic [15:0] oper_cond;
        logic [15:0] oper_ev;
        logic [15:0] oper_mask;
        logic [15:0] ques_cond;
        logic [15:0] ques_ev;
        logic [15:0] ques_mask;
        ssp_pkg::ssp_resp_t resp;
        logic err_post;
        logic [15:0] err_code;
        logic nvm_store;
        logic [VW-1:0] nvm_pos;
        logic [VW-1:0] nvm_neg;
        logic [7:0] sbyte;
    } ssp_state_t;

    ssp_state_t st;
    ssp_state_t next_st;

    // synchronised raw condition inputs
    logic [31:0] cond_sync;
    // conditions with unused positions forced to zero
    logic [15:0] oper_live;
    logic [15:0] ques_live;
    // event register read strobes
    logic oper_rd;
    logic ques_rd;
    // merge results
    logic [15:0] oper_next_ev;
    logic [15:0] oper_view;
    logic oper_next_sum;
    logic [15:0] ques_next_ev;
    logic [15:0] ques_view;
    logic ques_next_sum;
    // command value range checks
    logic over_guard;
    logic over_model;

    // condition pins come from the analogue side, so synchronise
    ssp_sync #(.W(32)) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({oper_cond_i, ques_cond_i}),
        .sync_o(cond_sync)
    );

    assign oper_live = cond_sync[31:16] & ssp_pkg::OPER_USED; // [RULE10]
    assign ques_live = cond_sync[15:0] & ssp_pkg::QUES_USED; // [RULE16]
    assign oper_rd = cmd_i.valid && (cmd_i.op == ssp_pkg::OP_OPER_EVENT_GET);
    assign ques_rd = cmd_i.valid && (cmd_i.op == ssp_pkg::OP_QUES_EVENT_GET);
    assign over_guard = cmd_i.value > GUARD_MAX;
    assign over_model = cmd_i.value > MODEL_MAX;

    // operation group: every used bit latches
    ssp_event_merge #(.USED(ssp_pkg::OPER_USED), .LATCHED(ssp_pkg::OPER_LATCHED)) u_oper (
        .cond_i(oper_live),
        .prev_i(st.oper_cond),
        .event_i(st.oper_ev),
        .mask_i(st.oper_mask),
        .clear_i(oper_rd),
        .next_event_o(oper_next_ev),
        .view_o(oper_view),
        .next_summary_o(oper_next_sum)
    );

    // questionable group: only current and voltage error latch
    ssp_event_merge #(.USED(ssp_pkg::QUES_USED), .LATCHED(ssp_pkg::QUES_LATCHED)) u_ques (
        .cond_i(ques_live),
        .prev_i(st.ques_cond),
        .event_i(st.ques_ev),
        .mask_i(st.ques_mask),
        .clear_i(ques_rd),
        .next_event_o(ques_next_ev),
        .view_o(ques_view),
        .next_summary_o(ques_next_sum)
    );

    // command decode and next state
    always_comb begin
        next_st = st;
        next_st.resp = '0;
        next_st.err_post = 1'b0;
        next_st.nvm_store = 1'b0;
        if (cmd_i.valid) begin
            case (cmd_i.op)
                ssp_pkg::OP_NEG_GUARD_SET: begin
                    if (over_guard) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        // guard never above its ceiling
                        next_st.neg_guard = (cmd_i.value > st.neg_ceil) ? st.neg_ceil : cmd_i.value; // [RULE1]
                    end
                end
                ssp_pkg::OP_POS_GUARD_SET: begin
                    if (over_guard) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        next_st.pos_guard = (cmd_i.value > st.pos_ceil) ? st.pos_ceil : cmd_i.value; // [RULE2]
                    end
                end
                ssp_pkg::OP_CEIL_BOTH_SET: begin
                    if (over_guard) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        // one value to both ceilings, guards pulled down to fit
                        next_st.pos_ceil = cmd_i.value; // [RULE3]
                        next_st.neg_ceil = cmd_i.value; // [RULE3]
                        next_st.pos_guard = (st.pos_guard > cmd_i.value) ? cmd_i.value : st.pos_guard;
                        next_st.neg_guard = (st.neg_guard > cmd_i.value) ? cmd_i.value : st.neg_guard;
                    end
                end
                ssp_pkg::OP_CEIL_NEG_SET: begin
                    if (over_guard) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        next_st.neg_ceil = cmd_i.value; // [RULE5]
                        next_st.neg_guard = (st.neg_guard > cmd_i.value) ? cmd_i.value : st.neg_guard;
                    end
                end
                ssp_pkg::OP_CEIL_POS_SET: begin
                    if (over_guard) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        next_st.pos_ceil = cmd_i.value; // [RULE5]
                        next_st.pos_guard = (st.pos_guard > cmd_i.value) ? cmd_i.value : st.pos_guard;
                    end
                end
                ssp_pkg::OP_STAGE_SET: begin
                    if (over_model) begin
                        // rejected, staged value kept
                        next_st.err_post = 1'b1; // [RULE7]
                    end else if (cmd_i.value > st.cap) begin
                        next_st.staged = st.cap; // [RULE8]
                    end else begin
                        next_st.staged = cmd_i.value; // [RULE6]
                    end
                end
                ssp_pkg::OP_CAP_SET: begin
                    if (over_model) begin
                        next_st.err_post = 1'b1;
                    end else begin
                        next_st.cap = cmd_i.value;
                    end
                end
                // trigger copies staged value to the output setpoint
                ssp_pkg::OP_TRIGGER: next_st.setpoint = st.staged; // [RULE6]
                // snapshot ceilings for the non-volatile store
                ssp_pkg::OP_PERSIST: begin
                    next_st.nvm_store = 1'b1; // [RULE3]
                    next_st.nvm_pos = st.pos_ceil; // [RULE5]
                    next_st.nvm_neg = st.neg_ceil; // [RULE5]
                end
                ssp_pkg::OP_OPER_MASK_SET: next_st.oper_mask = cmd_i.value[15:0] & ssp_pkg::OPER_USED; // [RULE13]
                ssp_pkg::OP_QUES_MASK_SET: next_st.ques_mask = cmd_i.value[15:0] & ssp_pkg::QUES_USED; // [RULE20]
                ssp_pkg::OP_PRESET: begin
                    next_st.oper_mask = ssp_pkg::OPER_PRESET & ssp_pkg::OPER_USED; // [RULE14]
                    next_st.ques_mask = ssp_pkg::QUES_PRESET & ssp_pkg::QUES_USED; // [RULE14]
                end
                // queries answer next cycle
                ssp_pkg::OP_NEG_GUARD_GET: next_st.resp = '{1'b1, st.neg_guard, VW'(0)}; // [RULE1]
                ssp_pkg::OP_POS_GUARD_GET: next_st.resp = '{1'b1, st.pos_guard, VW'(0)}; // [RULE2]
                ssp_pkg::OP_CEIL_BOTH_GET: next_st.resp = '{1'b1, st.pos_ceil, st.neg_ceil}; // [RULE4]
                ssp_pkg::OP_CEIL_NEG_GET: next_st.resp = '{1'b1, st.neg_ceil, VW'(0)}; // [RULE5]
                ssp_pkg::OP_CEIL_POS_GET: next_st.resp = '{1'b1, st.pos_ceil, VW'(0)}; // [RULE5]
                ssp_pkg::OP_STAGE_GET: next_st.resp = '{1'b1, st.staged, VW'(0)}; // [RULE6]
                ssp_pkg::OP_CAP_GET: next_st.resp = '{1'b1, st.cap, VW'(0)};
                ssp_pkg::OP_OPER_COND_GET: next_st.resp = '{1'b1, VW'(st.oper_cond), VW'(0)}; // [RULE9]
                ssp_pkg::OP_OPER_MASK_GET: next_st.resp = '{1'b1, VW'(st.oper_mask), VW'(0)}; // [RULE13]
                ssp_pkg::OP_OPER_EVENT_GET: next_st.resp = '{1'b1, VW'(oper_view), VW'(0)}; // [RULE12]
                ssp_pkg::OP_QUES_COND_GET: next_st.resp = '{1'b1, VW'(st.ques_cond), VW'(0)}; // [RULE17]
                ssp_pkg::OP_QUES_MASK_GET: next_st.resp = '{1'b1, VW'(st.ques_mask), VW'(0)};
                ssp_pkg::OP_QUES_EVENT_GET: next_st.resp = '{1'b1, VW'(ques_view), VW'(0)}; // [RULE15]
                default: next_st.resp = '0;
            endcase
            // every refusal reports data out of range
            if (next_st.err_post) begin
                next_st.err_code = ssp_pkg::ERR_OUT_OF_RANGE; // [RULE7]
            end
        end
        // live conditions, no latching, both regulation faults may coexist
        next_st.oper_cond = oper_live; // [RULE9]
        next_st.ques_cond = ques_live; // [RULE17] [RULE18]
        next_st.oper_ev = oper_next_ev; // [RULE12]
        next_st.ques_ev = ques_next_ev; // [RULE15]
        next_st.sbyte = 8'h00;
        next_st.sbyte[ssp_pkg::SB_OPER_BIT] = oper_next_sum; // [RULE11]
        next_st.sbyte[ssp_pkg::SB_QUES_BIT] = ques_next_sum; // [RULE19]
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
            st.pos_guard <= GUARD_MAX;
            st.neg_guard <= GUARD_MAX;
            st.pos_ceil <= GUARD_MAX;
            st.neg_ceil <= GUARD_MAX;
            st.cap <= MODEL_MAX;
            st.staged <= ssp_pkg::VOLT_RESET;
            st.setpoint <= ssp_pkg::VOLT_RESET;
            st.oper_mask <= ssp_pkg::REG_RESET;
            st.ques_mask <= ssp_pkg::REG_RESET;
            st.err_code <= ssp_pkg::ERR_NONE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign resp_o = st.resp;
    assign err_post_o = st.err_post;
    assign err_code_o = st.err_code;
    assign setpoint_o = st.setpoint;
    assign pos_guard_o = st.pos_guard;
    assign neg_guard_o = st.neg_guard;
    assign nvm_store_o = st.nvm_store;
    assign nvm_pos_ceil_o = st.nvm_pos;
    assign nvm_neg_ceil_o = st.nvm_neg;
    assign status_byte_o = st.sbyte;

    // checks on the registered behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_cmd(ssp_pkg::ssp_op_t op);
        cmd_i.valid && cmd_i.op == op;
    endsequence
    sequence s_oper_read;
        s_cmd(ssp_pkg::OP_OPER_EVENT_GET);
    endsequence

    property p_neg_guard;
        s_cmd(ssp_pkg::OP_NEG_GUARD_SET) ##0 (cmd_i.value <= neg_guard_o && !over_guard)
            |=> neg_guard_o == $past(cmd_i.value) && !err_post_o;
    endproperty
    a_neg_guard: assert property (p_neg_guard) else $error("neg guard not stored"); // [RULE1]
    property p_pos_guard;
        pos_guard_o <= GUARD_MAX && pos_guard_o <= st.pos_ceil;
    endproperty
    a_pos_guard: assert property (p_pos_guard) else $error("pos guard above bound"); // [RULE2]
    property p_ceil_both;
        s_cmd(ssp_pkg::OP_CEIL_BOTH_SET) ##0 !over_guard |=> st.pos_ceil == st.neg_ceil && st.pos_ceil == $past(cmd_i.value);
    endproperty
    a_ceil_both: assert property (p_ceil_both) else $error("ceilings not set together"); // [RULE3]
    property p_ceil_query;
        s_cmd(ssp_pkg::OP_CEIL_BOTH_GET) |=> resp_o.valid && resp_o.first == st.pos_ceil && resp_o.second == st.neg_ceil;
    endproperty
    a_ceil_query: assert property (p_ceil_query) else $error("ceiling answer order wrong"); // [RULE4]
    property p_trigger;
        s_cmd(ssp_pkg::OP_TRIGGER) |=> setpoint_o == $past(st.staged);
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger did not load setpoint"); // [RULE6]
    property p_stage_reject;
        s_cmd(ssp_pkg::OP_STAGE_SET) ##0 over_model |=> err_post_o && err_code_o == ssp_pkg::ERR_OUT_OF_RANGE && $stable(st.staged);
    endproperty
    a_stage_reject: assert property (p_stage_reject) else $error("out of range stage not rejected"); // [RULE7]
    property p_stage_clamp;
        s_cmd(ssp_pkg::OP_STAGE_SET) ##0 (!over_model && cmd_i.value > st.cap) |=> st.staged == $past(st.cap) && !err_post_o;
    endproperty
    a_stage_clamp: assert property (p_stage_clamp) else $error("stage not clamped to cap"); // [RULE8]
    property p_oper_clear;
        s_oper_read ##0 (oper_live & ~st.oper_cond) == 16'h0000 |=> st.oper_ev == 16'h0000 ##1 1'b1;
    endproperty
    a_oper_clear: assert property (p_oper_clear) else $error("operation events not cleared on read"); // [RULE12]
    property p_oper_sum;
        status_byte_o[ssp_pkg::SB_OPER_BIT] == |(oper_view & $past(st.oper_mask));
    endproperty
    a_oper_sum: assert property (p_oper_sum) else $error("operation summary wrong"); // [RULE11]
    property p_ques_sum;
        status_byte_o[ssp_pkg::SB_QUES_BIT] == |(ques_view & $past(st.ques_mask));
    endproperty
    a_ques_sum: assert property (p_ques_sum) else $error("questionable summary wrong"); // [RULE19]
    property p_unused_zero;
        (st.oper_mask & ~ssp_pkg::OPER_USED) == 16'h0000 && (st.ques_ev & ~ssp_pkg::QUES_LATCHED) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set"); // [RULE20]
endmodule
`default_nettype wire

/* File: hw/ssp_top_end.sv */
// no logic lives in this file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
